// ### rtl/msgh_accept.sv
`timescale 1ns/1ps
module msgh_accept
	import msgh_pkg::*;
(
	// object table and frame under test
	input wire msgh_obj_t objs_i [NUM_OBJ],
	input wire msgh_frame_t frame_i,
	// result
	output logic [31:0] match_o,
	output logic hit_o,
	output logic [4:0] idx_o
);

	// one object against one frame
	function automatic logic msgh_match(input msgh_obj_t o, input msgh_frame_t f);
		logic [28:0] care;
		logic ext_care;
		logic dir_care;
		care = o.ctl.use_acceptance_mask ? o.msk.id_mask_bits : ID_ALL;
		care = care & (f.extended_id_flag ? ID_ALL : ID_STD);
		ext_care = o.ctl.use_acceptance_mask ? o.msk.mask_extended_flag : 1'b1;
		dir_care = o.ctl.use_acceptance_mask ? o.msk.mask_direction : 1'b1;
		return o.arb.object_valid && (((o.arb.ident ^ f.ident) & care) == '0)
			&& (!ext_care || o.arb.extended_id_flag == f.extended_id_flag)
			&& (!dir_care || o.arb.direction_bit == f.remote);
	endfunction

	// scan all objects, lowest number wins
	always_comb begin
		logic [5:0] first;
		first = '0;
		for (int i = 0; i < NUM_OBJ; i++) begin
			match_o[i] = msgh_match(objs_i[i], frame_i);
		end
		first = msgh_first(match_o);
		hit_o = first[5];
		idx_o = first[4:0];
	end

endmodule // msgh_accept

// ### rtl/msgh_core.sv
`timescale 1ns/1ps
module msgh_core
	import msgh_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// received frames from the protocol engine
	input wire logic rx_valid_i,
	input wire msgh_frame_t rx_frame_i,
	// frames offered to the protocol engine
	output logic tx_valid_o,
	output logic [5:0] tx_obj_o,
	output msgh_frame_t tx_frame_o,
	input wire logic tx_take_i,
	input wire logic tx_done_i
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	msgh_obj_t objs [NUM_OBJ];
	msgh_obj_t if_obj;
	logic [7:0] if_cmask;
	logic [5:0] crq_num;
	logic tx_lock;
	logic [31:0] match_vec;
	logic rx_hit;
	logic [4:0] rx_idx;
	logic [31:0] pend_vec;
	logic [31:0] newd_vec;
	logic [31:0] irq_vec;
	logic [5:0] pend_first;
	logic acc_wr;
	logic acc_rd;
	logic crq_ok;
	logic crq_go;
	logic [4:0] crq_idx;
	logic [4:0] tx_idx;
	logic tx_fin;
	logic [31:0] rd_val;
	logic map_ok;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// write lands at the edge where pready is sampled high
	assign acc_wr = psel_i & penable_i & pready_o & pwrite_i;
	assign acc_rd = psel_i & penable_i & ~pready_o;
	assign crq_ok = (pwdata_i[5:0] >= OBJ_FIRST) && (pwdata_i[5:0] <= OBJ_LAST);
	assign crq_go = acc_wr && (paddr_i == OFF_CRQ) && crq_ok;
	assign crq_idx = 5'(pwdata_i[5:0] - OBJ_FIRST);
	assign tx_idx = 5'(tx_obj_o - OBJ_FIRST);
	assign tx_fin = tx_done_i & tx_lock;

	// ----------------------------------------------------------------
	// acceptance filter
	// ----------------------------------------------------------------
	msgh_accept u_accept (
		.objs_i(objs),
		.frame_i(rx_frame_i),
		.match_o(match_vec),
		.hit_o(rx_hit),
		.idx_o(rx_idx)
	);

	// per-object status vectors
	always_comb begin
		for (int i = 0; i < NUM_OBJ; i++) begin
			pend_vec[i] = objs[i].arb.object_valid & objs[i].ctl.transmit_request_flag;
			newd_vec[i] = objs[i].ctl.new_data_flag;
			irq_vec[i] = objs[i].ctl.object_irq_pending;
		end
		pend_first = msgh_first(pend_vec);
	end

	// ----------------------------------------------------------------
	// message ram
	// ----------------------------------------------------------------
	// order: software transfer, then transmit completion, then reception;
	// later statements win, so hardware sets beat software clears
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < NUM_OBJ; i++) begin
				objs[i] <= '0;
			end
		end else begin
			if (crq_go && if_cmask[CM_WRITE]) begin
				if (if_cmask[CM_MASK]) objs[crq_idx].msk <= if_obj.msk;
				if (if_cmask[CM_ARB]) objs[crq_idx].arb <= if_obj.arb;
				if (if_cmask[CM_CTRL]) objs[crq_idx].ctl <= if_obj.ctl;
				if (if_cmask[CM_NEWTX]) objs[crq_idx].ctl.transmit_request_flag <= 1'b1;
				if (if_cmask[CM_DATA_A]) objs[crq_idx].data[31:0] <= if_obj.data[31:0];
				if (if_cmask[CM_DATA_B]) objs[crq_idx].data[63:32] <= if_obj.data[63:32];
			end else if (crq_go) begin
				// read transfer acknowledges the object
				if (if_cmask[CM_CLRIRQ]) objs[crq_idx].ctl.object_irq_pending <= 1'b0;
				if (if_cmask[CM_NEWTX]) objs[crq_idx].ctl.new_data_flag <= 1'b0;
			end
			if (tx_fin) begin
				objs[tx_idx].ctl.transmit_request_flag <= 1'b0;
				if (objs[tx_idx].ctl.tx_irq_enable) objs[tx_idx].ctl.object_irq_pending <= 1'b1;
			end
			if (rx_valid_i && rx_hit) begin
				if (!rx_frame_i.remote) begin
					objs[rx_idx].arb.ident <= rx_frame_i.ident;
					objs[rx_idx].arb.extended_id_flag <= rx_frame_i.extended_id_flag;
					objs[rx_idx].ctl.dlc <= rx_frame_i.dlc;
					objs[rx_idx].data <= rx_frame_i.data;
					objs[rx_idx].ctl.new_data_flag <= 1'b1;
					objs[rx_idx].ctl.message_lost_flag <= objs[rx_idx].ctl.message_lost_flag
						| objs[rx_idx].ctl.new_data_flag;
					if (objs[rx_idx].ctl.rx_irq_enable) objs[rx_idx].ctl.object_irq_pending <= 1'b1;
				end else if (objs[rx_idx].ctl.remote_answer_enable) begin
					objs[rx_idx].ctl.transmit_request_flag <= 1'b1;
				end else if (objs[rx_idx].ctl.use_acceptance_mask) begin
					// data field left alone, software answers later
					objs[rx_idx].ctl.transmit_request_flag <= 1'b0;
					objs[rx_idx].arb.ident <= rx_frame_i.ident;
					objs[rx_idx].arb.extended_id_flag <= rx_frame_i.extended_id_flag;
					objs[rx_idx].ctl.dlc <= rx_frame_i.dlc;
					objs[rx_idx].ctl.new_data_flag <= 1'b1;
					objs[rx_idx].ctl.message_lost_flag <= objs[rx_idx].ctl.message_lost_flag
						| objs[rx_idx].ctl.new_data_flag;
				end
				// remaining case: frame dropped without trace
			end
		end
	end

	// ----------------------------------------------------------------
	// interface register set
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			if_obj <= '0;
			if_cmask <= CMASK_RST;
			crq_num <= CRQ_RST;
		end else begin
			if (acc_wr) begin
				case (paddr_i)
					OFF_CMASK: if_cmask <= pwdata_i[7:0];
					OFF_CRQ: crq_num <= pwdata_i[5:0];
					OFF_MSK_LO: if_obj.msk[15:0] <= pwdata_i[15:0];
					OFF_MSK_HI: if_obj.msk[31:16] <= {pwdata_i[15:14], 1'b0, pwdata_i[12:0]};
					OFF_ARB_LO: if_obj.arb[15:0] <= pwdata_i[15:0];
					OFF_ARB_HI: if_obj.arb[31:16] <= pwdata_i[15:0];
					OFF_MCTL: if_obj.ctl <= {pwdata_i[MC_FLAG_HI:MC_FLAG_LO], pwdata_i[MC_DLC_HI:0]};
					OFF_DA_LO: if_obj.data[15:0] <= pwdata_i[15:0];
					OFF_DA_HI: if_obj.data[31:16] <= pwdata_i[15:0];
					OFF_DB_LO: if_obj.data[47:32] <= pwdata_i[15:0];
					OFF_DB_HI: if_obj.data[63:48] <= pwdata_i[15:0];
					default: ;
				endcase
			end
			// read transfer shows flags as they were before any clear
			if (crq_go && !if_cmask[CM_WRITE]) begin
				if (if_cmask[CM_MASK]) if_obj.msk <= objs[crq_idx].msk;
				if (if_cmask[CM_ARB]) if_obj.arb <= objs[crq_idx].arb;
				if (if_cmask[CM_CTRL]) if_obj.ctl <= objs[crq_idx].ctl;
				if (if_cmask[CM_DATA_A]) if_obj.data[31:0] <= objs[crq_idx].data[31:0];
				if (if_cmask[CM_DATA_B]) if_obj.data[63:32] <= objs[crq_idx].data[63:32];
			end
		end
	end

	// read mux; reserved bits read zero
	always_comb begin
		rd_val = '0;
		map_ok = 1'b1;
		case (paddr_i)
			OFF_CMASK: rd_val[7:0] = if_cmask;
			OFF_CRQ: rd_val[5:0] = crq_num;
			OFF_MSK_LO: rd_val[15:0] = if_obj.msk[15:0];
			OFF_MSK_HI: rd_val[15:0] = if_obj.msk[31:16];
			OFF_ARB_LO: rd_val[15:0] = if_obj.arb[15:0];
			OFF_ARB_HI: rd_val[15:0] = if_obj.arb[31:16];
			OFF_MCTL: rd_val[15:0] = {if_obj.ctl[12:4], 3'h0, if_obj.ctl.dlc};
			OFF_DA_LO: rd_val[15:0] = if_obj.data[15:0];
			OFF_DA_HI: rd_val[15:0] = if_obj.data[31:16];
			OFF_DB_LO: rd_val[15:0] = if_obj.data[47:32];
			OFF_DB_HI: rd_val[15:0] = if_obj.data[63:48];
			OFF_TXPEND: rd_val = pend_vec;
			OFF_NEWVEC: rd_val = newd_vec;
			OFF_IRQVEC: rd_val = irq_vec;
			default: map_ok = 1'b0;
		endcase
	end

	// one wait state keeps every bus output on a flop
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= '0;
		end else begin
			pready_o <= acc_rd;
			pslverr_o <= acc_rd & ~map_ok;
			if (acc_rd) prdata_o <= pwrite_i ? 32'h0 : rd_val;
		end
	end

	// ----------------------------------------------------------------
	// transmit selection
	// ----------------------------------------------------------------
	// offer follows the lowest pending object until the engine takes it
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_valid_o <= 1'b0;
			tx_obj_o <= '0;
			tx_frame_o <= '0;
		end else if (tx_fin) begin
			tx_valid_o <= 1'b0;
		end else if (!tx_lock) begin
			tx_valid_o <= pend_first[5];
			tx_obj_o <= 6'({1'b0, pend_first[4:0]} + OBJ_FIRST);
			tx_frame_o.ident <= objs[pend_first[4:0]].arb.ident;
			tx_frame_o.extended_id_flag <= objs[pend_first[4:0]].arb.extended_id_flag;
			tx_frame_o.remote <= ~objs[pend_first[4:0]].arb.direction_bit;
			tx_frame_o.dlc <= objs[pend_first[4:0]].ctl.dlc;
			tx_frame_o.data <= objs[pend_first[4:0]].data;
		end
	end

	// lock holds the offer stable for the whole bus transfer
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_lock <= 1'b0;
		end else if (tx_done_i) begin
			tx_lock <= 1'b0;
		end else if (tx_take_i && tx_valid_o) begin
			tx_lock <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	msgh_obj_t chk_obj;
	msgh_frame_t chk_frame;
	msgh_arb_t chk_arb;
	logic [4:0] chk_idx;
	logic [4:0] chk_cidx;
	logic [31:0] chk_pend;
	logic quiet;
	logic lower_pend;

	assign quiet = !crq_go && !tx_fin;
	assign lower_pend = |(chk_pend & ((32'h1 << (tx_obj_o - OBJ_FIRST)) - 32'h1));

	// snapshot of the object before the event
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chk_obj <= '0;
			chk_frame <= '0;
			chk_arb <= '0;
			chk_idx <= '0;
			chk_cidx <= '0;
			chk_pend <= '0;
		end else begin
			chk_obj <= objs[rx_idx];
			chk_frame <= rx_frame_i;
			chk_arb <= if_obj.arb;
			chk_idx <= rx_idx;
			chk_cidx <= crq_idx;
			chk_pend <= pend_vec;
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	a_remote_auto_set: assert property (
		rx_valid_i && rx_hit && rx_frame_i.remote && objs[rx_idx].ctl.remote_answer_enable
		|=> objs[chk_idx].ctl.transmit_request_flag && objs[chk_idx].data == chk_obj.data
	) else $error("auto answer did not raise transmit request");

	a_remote_ignored: assert property (
		rx_valid_i && rx_hit && rx_frame_i.remote && !objs[rx_idx].ctl.remote_answer_enable
		&& !objs[rx_idx].ctl.use_acceptance_mask && quiet
		|=> objs[chk_idx] == chk_obj
	) else $error("ignored remote frame changed the object");

	a_remote_stored: assert property (
		rx_valid_i && rx_hit && rx_frame_i.remote && !objs[rx_idx].ctl.remote_answer_enable
		&& objs[rx_idx].ctl.use_acceptance_mask && quiet
		|=> !objs[chk_idx].ctl.transmit_request_flag && objs[chk_idx].ctl.new_data_flag
		&& objs[chk_idx].data == chk_obj.data && objs[chk_idx].arb.ident == chk_frame.ident
		&& objs[chk_idx].ctl.dlc == chk_frame.dlc
	) else $error("stored remote frame wrong");

	a_tx_lowest_first: assert property (
		tx_valid_o && !tx_lock |-> !lower_pend && chk_pend[tx_idx]
	) else $error("offered object is not the lowest pending");

	a_unmasked_exact: assert property (
		rx_valid_i && rx_hit && !objs[rx_idx].ctl.use_acceptance_mask && rx_frame_i.extended_id_flag
		|-> objs[rx_idx].arb.ident == rx_frame_i.ident && objs[rx_idx].arb.extended_id_flag
	) else $error("unmasked object matched a different identifier");

	a_std_id_region: assert property (
		rx_hit && !rx_frame_i.extended_id_flag && !objs[rx_idx].ctl.use_acceptance_mask
		|-> objs[rx_idx].arb.ident[28:18] == rx_frame_i.ident[28:18]
	) else $error("standard identifier compared in the wrong bits");

	a_first_match: assert property (
		rx_hit |-> match_vec[rx_idx] && ((match_vec & ((32'h1 << rx_idx) - 32'h1)) == '0)
	) else $error("a lower object also matched");

	a_data_stored: assert property (
		rx_valid_i && rx_hit && !rx_frame_i.remote && quiet
		|=> objs[chk_idx].data == chk_frame.data && objs[chk_idx].ctl.new_data_flag
		&& objs[chk_idx].ctl.message_lost_flag == (chk_obj.ctl.message_lost_flag | chk_obj.ctl.new_data_flag)
	) else $error("data frame store or lost flag wrong");

	a_rx_irq_set: assert property (
		rx_valid_i && rx_hit && !rx_frame_i.remote && objs[rx_idx].ctl.rx_irq_enable
		|=> objs[chk_idx].ctl.object_irq_pending
	) else $error("receive interrupt pending not set");

	a_commit_arb: assert property (
		crq_go && if_cmask[CM_WRITE] && if_cmask[CM_ARB] && !rx_valid_i
		|=> objs[chk_cidx].arb == chk_arb
	) else $error("commit did not load arbitration fields");

	c_remote_auto: cover property (rx_valid_i && rx_hit && rx_frame_i.remote
		&& objs[rx_idx].ctl.remote_answer_enable);
	c_msg_lost: cover property (rx_valid_i && rx_hit && !rx_frame_i.remote
		&& objs[rx_idx].ctl.new_data_flag);
	c_mask_zero: cover property (rx_valid_i && rx_hit && objs[rx_idx].ctl.use_acceptance_mask
		&& objs[rx_idx].msk == '0);
	c_tx_done: cover property (tx_fin);

endmodule // msgh_core

// ### shared/msgh_pkg.sv
// Behaviour
// - remote frame, auto answer on: set transmit request, keep object, send soon.
// - remote frame, auto answer off, no mask: ignore, object fully unchanged.
// - auto off, mask on: clear request, store arbitration and length, flag new data.
// - lowest object number transmits first, identifiers do not matter.
// - mask registers act on matching only when the object uses the mask.
// - high mask bits 12..0 cover id 28..16; 12..2 cover standard id 10..0.
// - mask flags gate extended and direction compare; all-zero mask passes all.
// - receive interrupt enable sets irq pending after each stored data frame, not after a stored remote frame.
// - writing object number commits; reception into it starts at once.
// - data frame stores length and eight bytes, byte 0 in lowest data bits.
// - bytes beyond the length may be overwritten with unspecified values.
// - objects compared from object 1 upward, first match wins.
// - stored frame sets new data; if already set, also sets message lost.
package msgh_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_OBJ = 32;
	localparam logic [5:0] OBJ_FIRST = 6'h01;
	localparam logic [5:0] OBJ_LAST = 6'h20;
	localparam logic [28:0] ID_ALL = 29'h1FFFFFFF;
	localparam logic [28:0] ID_STD = 29'h1FFC0000;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_CMASK = 12'h000;
	localparam logic [11:0] OFF_CRQ = 12'h004;
	localparam logic [11:0] OFF_MSK_LO = 12'h008;
	localparam logic [11:0] OFF_MSK_HI = 12'h00C;
	localparam logic [11:0] OFF_ARB_LO = 12'h010;
	localparam logic [11:0] OFF_ARB_HI = 12'h014;
	localparam logic [11:0] OFF_MCTL = 12'h018;
	localparam logic [11:0] OFF_DA_LO = 12'h01C;
	localparam logic [11:0] OFF_DA_HI = 12'h020;
	localparam logic [11:0] OFF_DB_LO = 12'h024;
	localparam logic [11:0] OFF_DB_HI = 12'h028;
	localparam logic [11:0] OFF_TXPEND = 12'h02C;
	localparam logic [11:0] OFF_NEWVEC = 12'h030;
	localparam logic [11:0] OFF_IRQVEC = 12'h034;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CM_WRITE = 7;
	localparam int CM_MASK = 6;
	localparam int CM_ARB = 5;
	localparam int CM_CTRL = 4;
	localparam int CM_CLRIRQ = 3;
	localparam int CM_NEWTX = 2;
	localparam int CM_DATA_A = 1;
	localparam int CM_DATA_B = 0;
	localparam int MC_FLAG_HI = 15;
	localparam int MC_FLAG_LO = 7;
	localparam int MC_DLC_HI = 3;
	localparam int MK_RSV = 13;
	localparam logic [7:0] CMASK_RST = 8'h00;
	localparam logic [5:0] CRQ_RST = 6'h00;

	// ----------------------------------------------------------------
	// object and frame carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic mask_extended_flag;
		logic mask_direction;
		logic reserved;
		logic [28:0] id_mask_bits;
	} msgh_msk_t;

	typedef struct packed {
		logic object_valid;
		logic extended_id_flag;
		logic direction_bit;
		logic [28:0] ident;
	} msgh_arb_t;

	typedef struct packed {
		logic new_data_flag;
		logic message_lost_flag;
		logic object_irq_pending;
		logic use_acceptance_mask;
		logic tx_irq_enable;
		logic rx_irq_enable;
		logic remote_answer_enable;
		logic transmit_request_flag;
		logic end_of_buffer;
		logic [3:0] dlc;
	} msgh_ctl_t;

	typedef struct packed {
		msgh_msk_t msk;
		msgh_arb_t arb;
		msgh_ctl_t ctl;
		logic [63:0] data;
	} msgh_obj_t;

	typedef struct packed {
		logic [28:0] ident;
		logic extended_id_flag;
		logic remote;
		logic [3:0] dlc;
		logic [63:0] data;
	} msgh_frame_t;

	// lowest set bit: {found, index}
	function automatic logic [5:0] msgh_first(input logic [31:0] v);
		logic [5:0] r;
		r = '0;
		for (int i = NUM_OBJ - 1; i >= 0; i--) begin
			if (v[i]) r = {1'b1, 5'(i)};
		end
		return r;
	endfunction

endpackage

// ### tb/can_message_object_handler_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module can_message_object_handler_tb_top
	import msgh_pkg::*;
;
	logic ref_clk_i, resetn_i, psel_i, penable_i, pwrite_i, rx_valid_i, tx_take_i, tx_done_i, hold, sent;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic pready_o, pslverr_o, tx_valid_o;
	logic [5:0] tx_obj_o, sent_obj;
	msgh_frame_t rx_frame_i;
	int num_errors = 0;
	int tests_run = 0;
	logic [32:0] rd_q[$];
	logic [81:0] tx_q[$];
	msgh_frame_t txf;
	logic [63:0] da, db, dd, d10, d14;

	msgh_core i_msgh_core (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i), .rx_frame_i(rx_frame_i), .tx_valid_o(tx_valid_o),
		.tx_obj_o(tx_obj_o), .tx_frame_o(txf), .tx_take_i(tx_take_i), .tx_done_i(tx_done_i));
	msgh_engine_model i_msgh_engine_model (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .hold_i(hold),
		.tx_valid_i(tx_valid_o), .tx_obj_i(tx_obj_o), .tx_take_o(tx_take_i), .tx_done_o(tx_done_i),
		.sent_o(sent), .sent_obj_o(sent_obj));

	// ----------------------------------------------------------------
	// clock, verdict, bus and frame tasks
	// ----------------------------------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	task automatic test_done();
		if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// one apb transfer; waits for pready with a bound
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			test_done();
		end
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	// read with a note of {error, data} for the monitor
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		rd_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	// write-direction setup of one object from mask down to data
	task automatic cfg(input logic [5:0] o, input logic [15:0] mh, ah, mc, input logic [63:0] d);
		logic [15:0] v [9];
		v = '{16'h0000, mh, 16'h0000, ah, mc, d[15:0], d[31:16], d[47:32], d[63:48]};
		apb(1'b1, OFF_CMASK, 32'h000000F3);
		for (int i = 0; i < 9; i++) apb(1'b1, OFF_MSK_LO + 12'(4 * i), 32'(v[i]));
		apb(1'b1, OFF_CRQ, 32'(o));
	endtask

	// read-back of arb high, control and data of an object, clearing new data and irq
	task automatic robj(input logic [5:0] o, input logic [15:0] mc, ah, input logic [63:0] d);
		apb(1'b1, OFF_CMASK, 32'h0000007F);
		apb(1'b1, OFF_CRQ, 32'(o));
		rd(OFF_ARB_HI, 33'(ah));
		rd(OFF_MCTL, 33'(mc));
		for (int i = 0; i < 4; i++) rd(OFF_DA_LO + 12'(4 * i), 33'(d[16 * i +: 16]));
	endtask

	// one standard-id frame from the engine
	task automatic rxf(input logic [10:0] id, input logic rem, input logic [3:0] dl, input logic [63:0] d);
		rx_frame_i <= '{ident: {id, 18'h00000}, extended_id_flag: 1'b0, remote: rem, dlc: dl, data: d};
		rx_valid_i <= 1'b1;
		@(posedge ref_clk_i);
		rx_valid_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	// ----------------------------------------------------------------
	// monitors: oldest note against each result
	// ----------------------------------------------------------------
	always @(posedge ref_clk_i) begin
		logic [32:0] e;
		if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
			e = rd_q.pop_front();
			`CHK({pslverr_o, prdata_o}, e)
		end
	end

	always @(posedge ref_clk_i) begin
		logic [81:0] o;
		// offer stays frozen until the edge after done, so the frame is still readable here
		if (sent === 1'b1) begin
			o = tx_q.pop_front();
			`CHK({sent_obj, txf.remote, txf.ident[28:18], txf.data}, o)
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{resetn_i, psel_i, penable_i, pwrite_i, rx_valid_i, hold} = '0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		rx_frame_i = '0;
		void'($urandom(32'hA24C6C03));
		{da, db, dd, d10, d14} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
			$urandom, $urandom, $urandom};
		repeat (16) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		@(posedge ref_clk_i);
		rd(OFF_MCTL, 33'h0);
		rd(12'h100, 33'h100000000); // unmapped place
		// masked std, exact std, catch-all rx; auto, ignore and store tx
		cfg(6'd3, 16'hDFF0, 16'h8480, 16'h1488, 64'h0);
		cfg(6'd5, 16'h0000, 16'h8280, 16'h0488, 64'h0);
		cfg(6'd30, 16'h0000, 16'h9FFC, 16'h1488, 64'h0);
		cfg(6'd10, 16'h0000, 16'hAC00, 16'h0288, d10);
		cfg(6'd12, 16'h0000, 16'hAC04, 16'h0088, 64'h0);
		cfg(6'd14, 16'hDFFC, 16'hAC08, 16'h1088, d14);
		rxf(11'h121, 1'b0, 4'h8, da);
		rxf(11'h122, 1'b0, 4'h8, db);
		rxf(11'h0A0, 1'b0, 4'h8, da);
		rxf(11'h0A1, 1'b0, 4'h8, dd);
		rd(OFF_NEWVEC, 33'h020000014);
		robj(6'd3, 16'hF488, 16'h8488, db);
		robj(6'd30, 16'hB488, 16'h8284, dd);
		hold <= 1'b1;
		rxf(11'h301, 1'b1, 4'h8, 64'h0);
		rxf(11'h302, 1'b1, 4'h5, 64'h0);
		rd(OFF_TXPEND, 33'h0);
		rd(OFF_NEWVEC, 33'h000002010);
		robj(6'd14, 16'h9085, 16'hAC08, d14);
		apb(1'b1, OFF_CMASK, 32'h00000084);
		apb(1'b1, OFF_CRQ, 32'd14);
		apb(1'b1, OFF_CRQ, 32'd12);
		rxf(11'h300, 1'b1, 4'h8, 64'h0);
		rd(OFF_TXPEND, 33'h000002A00);
		tx_q = '{{6'd10, 1'b0, 11'h300, d10}, {6'd12, 1'b0, 11'h301, 64'h0}, {6'd14, 1'b0, 11'h302, d14}};
		hold <= 1'b0;
		for (int n = 0; n < 300 && tx_q.size() > 0; n++) @(posedge ref_clk_i);
		if (tx_q.size() > 0) num_errors++;
		rd(OFF_TXPEND, 33'h0);
		robj(6'd10, 16'h0288, 16'hAC00, d10);
		// extended frame into an exact, unmasked receive object
		cfg(6'd20, 16'h0000, 16'hC123, 16'h0488, 64'h0);
		rx_frame_i <= '{ident: 29'h01230000, extended_id_flag: 1'b1, remote: 1'b0, dlc: 4'h8, data: dd};
		rx_valid_i <= 1'b1;
		@(posedge ref_clk_i);
		rx_valid_i <= 1'b0;
		@(posedge ref_clk_i);
		robj(6'd20, 16'hA488, 16'hC123, dd);
		test_done();
	end

	// watchdog for a hung run
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		num_errors++;
		test_done();
	end
endmodule // can_message_object_handler_tb_top

// ### tb/msgh_engine_model.sv
`timescale 1ns/1ps
module msgh_engine_model
	import msgh_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// bench control: bus busy, engine may not start
	input wire logic hold_i,
	// offer side
	input wire logic tx_valid_i,
	input wire logic [5:0] tx_obj_i,
	output logic tx_take_o,
	output logic tx_done_o,
	// report of each finished frame
	output logic sent_o,
	output logic [5:0] sent_obj_o
);
	logic busy;
	logic [1:0] cnt;

	// take an offer, hold the bus four cycles, then report it sent
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy <= 1'b0;
			cnt <= 2'h0;
			tx_take_o <= 1'b0;
			tx_done_o <= 1'b0;
			sent_o <= 1'b0;
			sent_obj_o <= 6'h00;
		end else begin
			tx_take_o <= 1'b0;
			tx_done_o <= 1'b0;
			sent_o <= 1'b0;
			// skip the cycle of done: the offer is still up then
			if (!busy && !hold_i && tx_valid_i && !tx_take_o && !tx_done_o) begin
				tx_take_o <= 1'b1;
				busy <= 1'b1;
				cnt <= 2'h3;
			end else if (busy && cnt == 2'h0) begin
				tx_done_o <= 1'b1;
				sent_o <= 1'b1;
				sent_obj_o <= tx_obj_i; // offer is frozen while locked
				busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - 2'h1;
			end
		end
	end
endmodule // msgh_engine_model
